// ==== hdl/lpm_ctrl.sv ====
// low-power mode controller: stop, wait and slow modes with the control register.
// assumes the cpu core pulses stop_req or wait_req and obeys cpu_hold,
// and that the can controller reports its sleep state as a level.
`timescale 1ns/10ps
`default_nettype none
module lpm_ctrl
   import lpm_pkg::*;
#(
   parameter int          OSC_RATIO     = 2,            // mask divide 2, 4, 8 or 10
   parameter bit          LONG_STARTUP  = 1'b1,         // 4064 when set, else 16
   parameter bit          WATCHDOG_SERVICE_BIT_IN_WAIT  = 1'b0,         // watchdog runs in wait
   parameter int          STARTUP_LONG  = LPM_STARTUP_LONG
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // cpu core side
   input  wire logic        stop_req,
   input  wire logic        wait_req,
   input  wire logic        power_on_event,
   input  wire logic        osc_tick,
   input  wire logic        can_asleep,
   input  wire logic        can_irq,
   input  wire logic        wor_irq,
   input  wire logic        ext_irq,
   input  wire logic        other_irq,
   input  wire logic        watchdog_service_bit_service,
   output logic             cpu_hold,
   output logic             clear_imask,
   output logic             stack_now,
   output logic             fetch_reset_vec,
   output lpm_clk_t         clk_en,
   output lpm_periph_t      periph,
   output logic [7:0]       misc_control
);
   localparam int DLY_W = 12;
   // start-up count chosen by the manufacturing option
   localparam logic [DLY_W-1:0] STARTUP_CYC = LONG_STARTUP ?
      DLY_W'(STARTUP_LONG - 1) : DLY_W'(LPM_STARTUP_SHORT - 1);

   lpm_state_t        state;        // current mode
   lpm_state_t        next_state;   // mode for next cycle
   logic [DLY_W-1:0]  delay;        // start-up countdown
   logic              reg_wr;       // pending write data phase
   logic              addr_misc;    // pending access hits misc_control
   logic              addr_stat;    // pending access hits status
   logic              wake_irq;     // wake source latched as interrupt
   logic              bus_tick;     // divided cpu/periph tick

   // address phase decode
   wire   access     = hsel && hready && htrans[1];
   wire   hit_misc   = haddr == LPM_MISC_CONTROL_ADDR;
   wire   hit_stat   = haddr == LPM_STATUS_ADDR;
   wire   wr_misc    = reg_wr && addr_misc;
   // any interrupt source
   wire   any_irq    = can_irq || wor_irq || ext_irq || other_irq;
   // stop wake sources: can, wired-or, irq pin
   wire   stop_wake  = can_irq || wor_irq || (ext_irq && misc_control[LPM_EXT_IRQ_ENABLE_BIT]);
   // stop is only honoured while the can controller sleeps
   wire   stop_ok    = stop_req && can_asleep;
   wire   in_stop    = state == LPM_STOP;
   wire   in_wait    = state == LPM_WAIT;
   wire   in_start   = state == LPM_STARTUP;
   wire   delay_done = in_start && (delay == '0);

   // mode sequencing
   always_comb begin
      next_state = state;
      case (state)
         LPM_RUN: begin
            if (stop_ok) begin
               next_state = LPM_STOP;
            end else if (wait_req) begin
               next_state = LPM_WAIT;
            end
         end
         LPM_STOP: begin
            if (stop_wake) begin
               next_state = LPM_STARTUP;
            end
         end
         LPM_STARTUP: begin
            if (delay == '0) begin
               next_state = LPM_RUN;
            end
         end
         LPM_WAIT: begin
            if (any_irq) begin
               next_state = LPM_RUN;
            end
         end
         default: begin
            next_state = LPM_RUN;
         end
      endcase
   end

   // state and start-up counter; reset returns everything to run
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= LPM_RUN;
         delay <= '0;
      end else begin
         state <= next_state;
         if (in_stop && stop_wake) begin
            delay <= STARTUP_CYC;
         end else if (in_start && delay != '0) begin
            delay <= delay - 1'b1;
         end
      end
   end

   // record what woke the device; a reset exit never reaches here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_irq <= 1'b0;
      end else if (in_stop && stop_wake) begin
         wake_irq <= 1'b1;
      end else if (state == LPM_RUN) begin
         wake_irq <= 1'b0;
      end
   end

   // bus pipeline: capture address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reg_wr    <= 1'b0;
         addr_misc <= 1'b0;
         addr_stat <= 1'b0;
      end else begin
         reg_wr    <= access && hwrite;
         addr_misc <= access && hit_misc;
         addr_stat <= access && hit_stat;
      end
   end

   // misc_control register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         misc_control <= LPM_MISC_RESET;
      end else begin
         if (wr_misc) begin
            misc_control[6:1] <= hwdata[6:1];
         end
         if (state == LPM_RUN && stop_ok) begin
            misc_control[LPM_SLOW_BIT] <= 1'b0;
         end
         // power-on flag set by event, cleared by read
         if (power_on_event) begin
            misc_control[LPM_POR_BIT] <= 1'b1;
         end else if (addr_misc && !reg_wr) begin
            misc_control[LPM_POR_BIT] <= 1'b0;
         end
         // watchdog service bit follows core
         misc_control[LPM_WATCHDOG_SERVICE_BIT_BIT] <= watchdog_service_bit_service;
      end
   end

   lpm_divider #(
      .CNT_W (8)
   ) u_div (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .osc_tick (osc_tick && !in_stop),
      .ratio    (8'(OSC_RATIO)),
      .slow     (misc_control[LPM_SLOW_BIT]),
      .tick     (bus_tick)
   );

   // read data and response
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (access && !hwrite && hit_misc) begin
            hrdata <= {24'h000000, misc_control};
         end else if (access && !hwrite && hit_stat) begin
            hrdata <= {29'h0, state};
         end else begin
            hrdata <= 32'h00000000;
         end
      end
   end

   // cpu side and clock gating outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_hold        <= 1'b0;
         clear_imask     <= 1'b0;
         stack_now       <= 1'b0;
         fetch_reset_vec <= 1'b1;
         clk_en          <= '0;
         periph          <= '0;
      end else begin
         // cpu halted in stop, start-up and wait
         cpu_hold <= next_state != LPM_RUN;
         // stop clears mask; wait clears mask too
         clear_imask <= (state == LPM_RUN) && (stop_ok || wait_req);
         // stacking at stop exit; stacking at wait exit; service irq
         stack_now <= (delay_done && wake_irq) || (in_wait && any_irq);
         fetch_reset_vec <= 1'b0;
         clk_en.osc_run       <= next_state != LPM_STOP;
         clk_en.cpu_clk_en    <= bus_tick && next_state == LPM_RUN;
         clk_en.periph_clk_en <= bus_tick && next_state != LPM_STOP;
         clk_en.can_clk_en    <= osc_tick && next_state != LPM_STOP;
         // stop effects on peripherals; state held
         periph.watchdog_service_bit_reset <= next_state == LPM_STOP;
         periph.watchdog_service_bit_run   <= (next_state == LPM_RUN) || (next_state == LPM_STARTUP) ||
                              ((next_state == LPM_WAIT) && WATCHDOG_SERVICE_BIT_IN_WAIT);
         periph.eeprom_ro  <= next_state == LPM_STOP;
         periph.sci_halt   <= next_state == LPM_STOP;
         periph.timer_halt <= next_state == LPM_STOP;
         periph.dac_hold   <= next_state == LPM_STOP;
         periph.adc_off    <= next_state == LPM_STOP;
         periph.io_hold    <= next_state == LPM_STOP;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/lpm_divider.sv ====
// tick generator: divides the oscillator enable by a ratio, optionally by 16 more.
// assumes osc_tick is a one-cycle pulse per oscillator edge on hclk.
`timescale 1ns/10ps
`default_nettype none
module lpm_divider
   import lpm_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             osc_tick,
   input  wire logic [CNT_W-1:0] ratio,
   input  wire logic             slow,
   output logic                  tick
);
   logic [CNT_W-1:0] count;      // base divider count
   logic [3:0]       slow_count; // extra divide-by-16 count
   wire  base_wrap  = osc_tick && (count >= ratio - 1'b1);
   wire  slow_wrap  = (slow_count == 4'hf);
   wire  next_tick  = base_wrap && (!slow || slow_wrap);
   // count oscillator ticks, then the extra slow stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count      <= '0;
         slow_count <= 4'h0;
         tick       <= 1'b0;
      end else begin
         tick <= next_tick;
         if (osc_tick) begin
            count <= base_wrap ? '0 : count + 1'b1;
         end
         if (base_wrap) begin
            slow_count <= slow ? slow_count + 4'h1 : 4'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== hdl/lpm_pkg.sv ====
// package for the low-power mode controller: register map, field positions,
// reset values, state enumeration and carrier structs.
// assumes a single 125 MHz clock domain and a 32-bit ahb-lite register bus.
package lpm_pkg;
   // register byte address
   localparam logic [31:0] LPM_MISC_CONTROL_ADDR = 32'h0000000c;
   localparam logic [31:0] LPM_STATUS_ADDR       = 32'h00000010;
   // misc_control field positions
   localparam int LPM_POR_BIT    = 7;
   localparam int LPM_IRQ_RISING_SELECT_BIT   = 6;
   localparam int LPM_IRQ_FALLING_SELECT_BIT   = 5;
   localparam int LPM_EXT_IRQ_ENABLE_BIT   = 4;
   localparam int LPM_SFA_BIT    = 3;
   localparam int LPM_SFB_BIT    = 2;
   localparam int LPM_SLOW_BIT   = 1;
   localparam int LPM_WATCHDOG_SERVICE_BIT_BIT   = 0;
   // misc_control reset value, writable bits 6..1 (bit 7 and bit 0 special)
   localparam logic [7:0] LPM_MISC_RESET = 8'h10;
   // slow mode inserts this extra divide
   localparam int LPM_SLOW_DIV   = 16;
   // start-up delay figures in internal cycles
   localparam int LPM_STARTUP_SHORT = 16;
   localparam int LPM_STARTUP_LONG  = 4064;
   // mode of the controller
   typedef enum logic [2:0] {
      LPM_RUN,
      LPM_STOP,
      LPM_STARTUP,
      LPM_WAIT
   } lpm_state_t;
   // clock enables handed to the rest of the chip
   typedef struct packed {
      logic osc_run;      // oscillator running
      logic cpu_clk_en;   // cpu clock tick
      logic periph_clk_en;// timer, sci, a/d tick (slow-divided)
      logic can_clk_en;   // can controller tick, never slow-divided
   } lpm_clk_t;
   // effects of the power state on the peripherals
   typedef struct packed {
      logic watchdog_service_bit_reset;   // watchdog held in reset
      logic watchdog_service_bit_run;     // watchdog counting
      logic eeprom_ro;    // eeprom read-only
      logic sci_halt;     // serial activity halted
      logic timer_halt;   // timer count halted
      logic dac_hold;     // pulse_length_dac outputs held
      logic adc_off;      // a/d converter disabled
      logic io_hold;      // pins keep their states
   } lpm_periph_t;
endpackage

// ==== verif/low_power_mode_control_tb_top.sv ====
// testbench for the low-power controller: ahb-lite tasks and mode sequences.
// assumes lpm_ctrl, lpm_cpu_model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module low_power_mode_control_tb_top
   import lpm_pkg::*;
;
   localparam int SU = 40;                        // shortened start-up count
   localparam logic [31:0] A_M = LPM_MISC_CONTROL_ADDR;
   localparam logic [31:0] A_S = LPM_STATUS_ADDR;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, d;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;                    // whole words only
   logic go_stop = 1'b0, go_wait = 1'b0, can_asleep = 1'b0, other_irq = 1'b0;
   logic power_on_event = 1'b0, watchdog_service_bit_service = 1'b0;
   logic [2:0] wake = 3'b000;                     // can, wired-or, irq pin
   wire logic hready, hresp, stop_req, wait_req, cpu_hold, clear_imask;
   wire logic stack_now, fetch_reset_vec;
   wire lpm_clk_t clk_en;
   wire lpm_periph_t periph;
   wire logic [7:0] misc_control;
   int stacks, failures = 0, total_checks = 0, cycles = 0, n, p, c;
   lpm_ctrl #(.STARTUP_LONG(SU)) lpm_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .stop_req(stop_req), .wait_req(wait_req), .power_on_event(power_on_event),
      .osc_tick(1'b1), .can_asleep(can_asleep), .can_irq(wake[0]), .wor_irq(wake[1]),
      .ext_irq(wake[2]), .other_irq(other_irq), .watchdog_service_bit_service(watchdog_service_bit_service),
      .cpu_hold(cpu_hold), .clear_imask(clear_imask), .stack_now(stack_now),
      .fetch_reset_vec(fetch_reset_vec), .clk_en(clk_en), .periph(periph),
      .misc_control(misc_control));
   lpm_cpu_model lpm_cpu_model_i (.hclk(hclk), .hresetn(hresetn), .go_stop(go_stop),
      .go_wait(go_wait), .cpu_hold(cpu_hold), .stack_now(stack_now),
      .stop_req(stop_req), .wait_req(wait_req), .stacks(stacks));
   // free-running 8 ns clock
   initial begin
      forever #4 hclk = ~hclk;
   end
   // hang guard
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         wrap_up;
      end
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one single ahb-lite transfer, address phase then data phase
   task automatic bus(input logic w, input logic [31:0] a, wd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      d = hrdata;
   endtask
   task automatic rd(input logic [31:0] a, exp, input string what);
      bus(1'b0, a, '0);
      check(what, d, exp);
   endtask
   task automatic rst;
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      check("reset vector", {31'h0, fetch_reset_vec}, 1);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask
   task automatic pulse(input bit s);
      if (s) go_stop <= 1'b1;
      else go_wait <= 1'b1;
      @(posedge hclk);
      go_stop <= 1'b0;
      go_wait <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask
   task automatic hold_to(input logic v);
      n = 0;
      while (cpu_hold !== v && n < 5000) begin
         @(posedge hclk);
         n++;
      end
   endtask
   task automatic ticks;
      p = 0;
      c = 0;
      repeat (320) begin
         @(posedge hclk);
         p += int'(clk_en.periph_clk_en);
         c += int'(clk_en.can_clk_en);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      rst;
      rd(A_M, 32'h10, "misc reset");
      check("vector released", {31'h0, fetch_reset_vec}, 0);
      bus(1'b1, A_M, 32'h7e);
      watchdog_service_bit_service <= 1'b1;
      @(posedge hclk);
      rd(A_M, 32'h7f, "misc bits");
      watchdog_service_bit_service <= 1'b0;
      power_on_event <= 1'b1;
      @(posedge hclk);
      power_on_event <= 1'b0;
      rd(A_M, 32'hfe, "por flag");
      rd(A_M, 32'h7e, "por cleared");
      rd(32'h20, 32'h0, "unmapped");
      // slow divide, peripheral and can ticks counted meanwhile
      ticks;
      check("slow periph", {31'h0, p inside {[9:11]}}, 1);
      check("can unslowed", {31'h0, c inside {[319:321]}}, 1);
      bus(1'b1, A_M, 32'h7c);
      ticks;
      check("normal periph", {31'h0, p inside {[159:161]}}, 1);
      pulse(1'b1);
      check("refused stop", {30'h0, cpu_hold, clk_en.osc_run}, 1);
      can_asleep <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, A_M, 32'h7e);
         pulse(1'b1);
         check("stopped", {30'h0, cpu_hold, clk_en.osc_run}, 2);
         rd(A_S, 32'(LPM_STOP), "stop state");
         rd(A_M, 32'h7c, "slow cleared");
         wake[i] <= 1'b1;
         hold_to(1'b0);
         wake[i] <= 1'b0;
         check("startup", {31'h0, n inside {[SU:SU+6]}}, 1);
         repeat (3) @(posedge hclk);
         check("stacked", 32'(stacks), 32'(i + 1));
      end
      pulse(1'b0);
      rd(A_S, 32'(LPM_WAIT), "wait state");
      check("timer runs", {31'h0, periph.timer_halt}, 0);
      check("cpu clock off", {31'h0, clk_en.cpu_clk_en}, 0);
      other_irq <= 1'b1;
      hold_to(1'b0);
      other_irq <= 1'b0;
      check("wait exit", {31'h0, n < 6}, 1);
      rd(A_M, 32'h7c, "wait keeps");
      check("wait stacked", 32'(stacks), 32'h00000004);
      pulse(1'b0);
      rst;
      check("reset exit run", {31'h0, cpu_hold}, 0);
      rd(A_M, 32'h10, "reset exit");
      wrap_up;
   end
endmodule
bind lpm_ctrl lpm_ctrl_assertions #(.STARTUP_LONG(STARTUP_LONG)) lpm_ctrl_assertions_i (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .stop_req(stop_req), .wait_req(wait_req), .can_asleep(can_asleep),
   .other_irq(other_irq), .cpu_hold(cpu_hold), .clear_imask(clear_imask),
   .stack_now(stack_now), .clk_en(clk_en), .periph(periph), .misc_control(misc_control));
`default_nettype wire

// ==== verif/lpm_cpu_model.sv ====
// cpu core model: executes stop and wait, counts stacking events.
// assumes one-cycle go pulses from the bench after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module lpm_cpu_model (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic go_stop,
   input  wire logic go_wait,
   input  wire logic cpu_hold,
   input  wire logic stack_now,
   output logic      stop_req,
   output logic      wait_req,
   output int        stacks
);
   // a held core executes nothing; stacking counted as it happens
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_req <= 1'b0;
         wait_req <= 1'b0;
         stacks   <= 0;
      end else begin
         stop_req <= go_stop && !cpu_hold;
         wait_req <= go_wait && !cpu_hold;
         stacks   <= stacks + int'(stack_now);
      end
   end
endmodule
`default_nettype wire

// ==== verif/lpm_ctrl_assertions.sv ====
// checker for the low-power mode controller, watching its ports only.
// assumes lpm_pkg and a single hclk domain with hresetn active low.
`timescale 1ns/10ps
`default_nettype none
module lpm_ctrl_assertions
   import lpm_pkg::*;
#(
   parameter int STARTUP_LONG = LPM_STARTUP_LONG
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        stop_req,
   input wire logic        wait_req,
   input wire logic        can_asleep,
   input wire logic        other_irq,
   input wire logic        cpu_hold,
   input wire logic        clear_imask,
   input wire logic        stack_now,
   input wire lpm_clk_t    clk_en,
   input wire lpm_periph_t periph,
   input wire logic [7:0]  misc_control
);
   logic        in_wait;                    // an accepted wait is pending
   logic        su_on;                      // oscillator stopped or restarted, cpu still held
   logic [12:0] su_cnt;                     // held cycles since the oscillator restarted
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // remember a wait so its exit can be timed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) in_wait <= 1'b0;
      else if (wait_req && !cpu_hold) in_wait <= 1'b1;
      else if (!cpu_hold) in_wait <= 1'b0;
   end
   // count held cycles from oscillator restart to cpu release, no long delay chains
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         su_on  <= 1'b0;
         su_cnt <= 13'h0000;
      end else if (!clk_en.osc_run) begin
         su_on  <= 1'b1;
         su_cnt <= 13'h0000;
      end else if (su_on && cpu_hold) begin
         su_cnt <= su_cnt + 13'h0001;
      end else if (!cpu_hold) begin
         su_on <= 1'b0;
      end
   end
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   chk_stop_entry: assert property (stop_req && can_asleep && !cpu_hold |=>
      cpu_hold && !clk_en.osc_run && clear_imask && !misc_control[LPM_SLOW_BIT])
      else $error("stop entry effects missing");
   chk_stop_refused: assert property (stop_req && !can_asleep && !cpu_hold |=>
      !cpu_hold && clk_en.osc_run) else $error("stop taken while can awake");
   chk_stop_periph: assert property ($fell(clk_en.osc_run) |-> ##[0:1]
      (periph.watchdog_service_bit_reset && periph.eeprom_ro && periph.sci_halt && periph.timer_halt
       && periph.dac_hold && periph.adc_off && periph.io_hold))
      else $error("stop peripheral effects wrong");
   chk_wait_entry: assert property (wait_req && !cpu_hold |=> cpu_hold && clear_imask
      && clk_en.osc_run && !periph.timer_halt && !periph.watchdog_service_bit_run)
      else $error("wait entry effects wrong");
   chk_startup_len: assert property (su_on && $fell(cpu_hold) |->
      su_cnt == 13'(STARTUP_LONG)) else $error("start-up delay length wrong");
   chk_no_early_stack: assert property (!clk_en.osc_run |-> !stack_now)
      else $error("stacking while stopped");
   chk_wait_exit: assert property ($rose(other_irq) && in_wait |-> ##[1:4] !cpu_hold)
      else $error("interrupt did not end wait");
   chk_misc_reset: assert property ($rose(hresetn) |->
      misc_control[6:1] == LPM_MISC_RESET[6:1])
      else $error("misc reset value wrong");
endmodule
`default_nettype wire
